// *** hw/dstc_ctrl.sv ***
module dstc_ctrl
  import dstc_pkg::*;
#(
  parameter int LONG_PRESS_CYCLES = LONG_PRESS_CYC
)
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [DATA_W-1:0]   rdata,
  input  wire logic                factory_config_image,
  input  wire logic                gpio_ctrl,
  input  wire logic                pushbutton_n,
  input  wire logic                over_temp,
  output logic      [NUM_OUT-1:0]  reg_enable,
  output logic                     reset_out_n,
  output logic                     deep_sleep,
  output logic                     irq
);

  logic [1:0]              gpio_sync;
  logic [1:0]              pb_sync;
  logic [1:0]              temp_sync;
  logic                    deep_sleep_request;
  logic                    deep_sleep_combine_select;
  logic                    gpio_is_ctrl;
  logic                    thermal_interrupt_mask;
  logic [NUM_OUT-1:0]      ds_onoff;
  logic [NUM_OUT-1:0]      ls_onoff;
  logic [7:0]              delay_val [NUM_OUT];
  logic [PRESS_CNT_W-1:0]  press_cnt;
  logic                    long_press;
  logic                    long_press_q;
  logic [NUM_EV-1:0]       irq_stat;
  logic [NUM_EV-1:0]       irq_en;
  logic [NUM_EV-1:0]       events;
  logic [TICK_CNT_W-1:0]   tick_cnt;
  logic                    tick;
  logic                    enter_cond;
  logic                    strap_taken;
  logic [7:0]              out_cnt [NUM_OUT];
  logic [NUM_OUT-1:0]      out_on;
  logic [NUM_OUT-1:0]      target;
  dstc_state_t             state;
  dstc_state_t             next_state;

  // pin synchronisers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gpio_sync <= 2'h0;
      pb_sync   <= 2'h3;
      temp_sync <= 2'h0;
    end
    else
    begin
      gpio_sync <= {gpio_sync[0], gpio_ctrl};
      pb_sync   <= {pb_sync[0], pushbutton_n};
      temp_sync <= {temp_sync[0], over_temp};
    end
  end

  // pushbutton low-time counter
  always_ff @(posedge sys_clk)
  begin
    if (rst || pb_sync[1])
      press_cnt <= '0;
    else if (!long_press)
      press_cnt <= press_cnt + PRESS_CNT_W'(1);
  end

  assign long_press = (press_cnt > PRESS_CNT_W'(LONG_PRESS_CYCLES));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      long_press_q <= 1'b0;
    else
      long_press_q <= long_press;
  end

  // factory selector caught after reset release
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      strap_taken               <= 1'b0;
      deep_sleep_combine_select <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken               <= 1'b1;
      deep_sleep_combine_select <= factory_config_image;
    end
  end

  // control registers; the port stays live in every state
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      deep_sleep_request     <= 1'b0;
      gpio_is_ctrl           <= 1'b0;
      thermal_interrupt_mask <= 1'b0;
      ds_onoff               <= DS_ONOFF_RST[NUM_OUT-1:0];
      ls_onoff               <= LS_ONOFF_RST[NUM_OUT-1:0];
      irq_en                 <= IRQ_EN_RST;
    end
    else
    begin
      if (long_press)
        deep_sleep_request <= 1'b0;
      else if (wr_en && addr == REG_CTRL)
        deep_sleep_request <= wdata[CTRL_REQ_BIT];
      if (wr_en && addr == REG_CTRL)
        gpio_is_ctrl <= wdata[CTRL_GPIO_CFG];
      if (wr_en && addr == REG_MASK)
        thermal_interrupt_mask <= wdata[MASK_THERM_BIT];
      if (wr_en && addr == REG_DS_ONOFF)
        ds_onoff <= wdata[NUM_OUT-1:0];
      if (wr_en && addr == REG_LS_ONOFF)
        ls_onoff <= wdata[NUM_OUT-1:0];
      if (wr_en && addr == REG_IRQ_EN)
        irq_en <= wdata[NUM_EV-1:0];
    end
  end

  // per-output delay registers
  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_dly
    always_ff @(posedge sys_clk)
    begin
      if (rst)
        delay_val[i] <= DELAY_RST;
      else if (wr_en && addr == REG_DELAY_BASE + 8'(i))
        delay_val[i] <= wdata;
    end
  end

  // entry condition
  always_comb
  begin
    if (!gpio_is_ctrl)
      enter_cond = deep_sleep_request;
    else if (deep_sleep_combine_select)
      enter_cond = deep_sleep_request | gpio_sync[1];
    else
      enter_cond = deep_sleep_request & gpio_sync[1];
  end

  // power state machine
  always_comb
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
        if (temp_sync[1])
          next_state = ST_THERMAL;
        else if (enter_cond && !long_press)
          next_state = ST_DEEP;
      ST_DEEP:
        if (temp_sync[1])
          next_state = ST_THERMAL;
        else if (!enter_cond || long_press)
          next_state = ST_ACTIVE;
      ST_THERMAL:
        if (!temp_sync[1])
          next_state = ST_ACTIVE;
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= ST_ACTIVE;
    else
      state <= next_state;
  end

  // sequencing tick divider
  always_ff @(posedge sys_clk)
  begin
    if (rst || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + TICK_CNT_W'(1);
  end

  assign tick = (tick_cnt == TICK_CNT_W'(TICK_CYC - 1));

  // per-output sequencing: switch after own delay
  always_comb
  begin
    if (state == ST_DEEP)
      target = ds_onoff;
    else
      target = {NUM_OUT{1'b1}};
  end

  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_seq
    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        out_on[i]  <= 1'b1;
        out_cnt[i] <= '0;
      end
      else if (state == ST_THERMAL)
      begin
        out_on[i]  <= 1'b0;
        out_cnt[i] <= '0;
      end
      else if (out_on[i] == target[i])
        out_cnt[i] <= '0;
      else if (tick)
      begin
        if (out_cnt[i] >= delay_val[i])
        begin
          out_on[i]  <= target[i];
          out_cnt[i] <= '0;
        end
        else
          out_cnt[i] <= out_cnt[i] + 8'h01;
      end
    end
  end

  assign reg_enable  = (state == ST_THERMAL) ? '0 : out_on;
  assign reset_out_n = (state != ST_THERMAL);
  assign deep_sleep  = (state == ST_DEEP);

  // interrupt status, set wins over clear
  assign events[EV_THERM_BIT]    = (next_state == ST_THERMAL) && (state != ST_THERMAL)
                                   && !thermal_interrupt_mask;
  assign events[EV_DS_ENTER_BIT] = (next_state == ST_DEEP) && (state != ST_DEEP);
  assign events[EV_DS_EXIT_BIT]  = (next_state != ST_DEEP) && (state == ST_DEEP);
  assign events[EV_LONG_BIT]     = long_press && !long_press_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      irq_stat <= '0;
    else if (wr_en && addr == REG_IRQ_CLR)
      irq_stat <= (irq_stat & ~wdata[NUM_EV-1:0]) | events;
    else
      irq_stat <= irq_stat | events;
  end

  assign irq = |(irq_stat & irq_en);

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata <= '0;
    else if (rd_en)
    begin
      if (addr == REG_CTRL)
        rdata <= {5'h00, gpio_is_ctrl, deep_sleep_combine_select, deep_sleep_request};
      else if (addr == REG_MASK)
        rdata <= {2'h0, thermal_interrupt_mask, 5'h00};
      else if (addr == REG_STATUS)
        rdata <= {5'h00, long_press, state == ST_THERMAL, state == ST_DEEP};
      else if (addr == REG_IRQ_STAT)
        rdata <= {4'h0, irq_stat};
      else if (addr == REG_IRQ_EN)
        rdata <= {4'h0, irq_en};
      else if (addr == REG_DS_ONOFF)
        rdata <= {3'h0, ds_onoff};
      else if (addr == REG_LS_ONOFF)
        rdata <= {3'h0, ls_onoff};
      else if (addr >= REG_DELAY_BASE && addr < REG_DELAY_BASE + 8'(NUM_OUT))
        rdata <= delay_val[3'(addr - REG_DELAY_BASE)];
      else
        rdata <= '0;
    end
    else
      rdata <= '0;
  end

  // checks
  sequence s_hot2;
    temp_sync[1] ##1 temp_sync[1];
  endsequence

  a_and_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_ACTIVE && gpio_is_ctrl && !deep_sleep_combine_select && !temp_sync[1]
     && !long_press && !(deep_sleep_request && gpio_sync[1])) |=> state != ST_DEEP)
    else $error("and entry without both inputs");
  a_or_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_ACTIVE && gpio_is_ctrl && deep_sleep_combine_select && gpio_sync[1]
     && !temp_sync[1] && !long_press) |=> state == ST_DEEP)
    else $error("or entry missed");
  a_sel_fixed: assert property (@(posedge sys_clk) disable iff (rst)
    strap_taken |=> $stable(deep_sleep_combine_select))
    else $error("combine selector changed");
  a_req_only: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_ACTIVE && !gpio_is_ctrl && deep_sleep_request && !temp_sync[1]
     && !long_press) |=> state == ST_DEEP)
    else $error("request alone did not enter");
  a_deep_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_DEEP && !enter_cond) |=> state != ST_DEEP)
    else $error("deep sleep held without condition");
  a_long_clear: assert property (@(posedge sys_clk) disable iff (rst)
    long_press |=> !deep_sleep_request && state != ST_DEEP)
    else $error("long press did not clear request");
  a_thermal_off: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_THERMAL |-> reg_enable == '0 && !reset_out_n)
    else $error("outputs live in thermal state");
  a_therm_mask: assert property (@(posedge sys_clk) disable iff (rst)
    thermal_interrupt_mask |=> !$rose(irq_stat[EV_THERM_BIT]))
    else $error("masked thermal interrupt set");
  a_therm_enter: assert property (@(posedge sys_clk) disable iff (rst)
    s_hot2 |-> state == ST_THERMAL)
    else $error("thermal state not entered");
  a_therm_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_THERMAL && !temp_sync[1]) |=> state == ST_ACTIVE)
    else $error("thermal exit not to active");
  a_press_restart: assert property (@(posedge sys_clk) disable iff (rst)
    pb_sync[1] |=> press_cnt == '0)
    else $error("press counter not restarted");

endmodule // dstc_ctrl

// *** hw/dstc_pkg.sv ***
package dstc_pkg;

  // register bus
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam int          NUM_OUT          = 5;

  // register indices
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_MASK         = 8'h01;
  localparam logic [7:0]  REG_STATUS       = 8'h02;
  localparam logic [7:0]  REG_IRQ_STAT     = 8'h03;
  localparam logic [7:0]  REG_IRQ_CLR      = 8'h04;
  localparam logic [7:0]  REG_IRQ_EN       = 8'h05;
  localparam logic [7:0]  REG_DS_ONOFF     = 8'h06;
  localparam logic [7:0]  REG_LS_ONOFF     = 8'h07;
  localparam logic [7:0]  REG_DELAY_BASE   = 8'h10;

  // field positions
  localparam int          CTRL_REQ_BIT     = 0;
  localparam int          CTRL_SEL_BIT     = 1;
  localparam int          CTRL_GPIO_CFG    = 2;
  localparam int          MASK_THERM_BIT   = 5;
  localparam int          ST_DEEP_BIT      = 0;
  localparam int          ST_THERM_BIT     = 1;
  localparam int          ST_LONG_BIT      = 2;
  localparam int          EV_THERM_BIT     = 0;
  localparam int          EV_DS_ENTER_BIT  = 1;
  localparam int          EV_DS_EXIT_BIT   = 2;
  localparam int          EV_LONG_BIT      = 3;
  localparam int          NUM_EV           = 4;

  // reset values
  localparam logic [7:0]  DS_ONOFF_RST     = 8'h00;
  localparam logic [7:0]  LS_ONOFF_RST     = 8'h00;
  localparam logic [7:0]  DELAY_RST        = 8'h01;
  localparam logic [3:0]  IRQ_EN_RST       = 4'h0;

  // timing
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          LONG_PRESS_MS    = 32;
  localparam int          LONG_PRESS_CYC   = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int          PRESS_CNT_W      = 20;
  localparam int          TICK_US          = 10;
  localparam int          TICK_CYC         = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          TICK_CNT_W       = 8;

  typedef enum logic [1:0] {ST_ACTIVE, ST_DEEP, ST_THERMAL} dstc_state_t;

endpackage

// *** testbench/dstc_host_pins.sv ***
module dstc_host_pins
(
  input  wire logic sys_clk,
  output logic      gpio_ctrl,
  output logic      pushbutton_n,
  output logic      over_temp
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    gpio_ctrl    = 1'b0;
    pushbutton_n = 1'b1;
    over_temp    = 1'b0;
  end

  // host level on the gpio control pin
  task automatic set_gpio(input logic v);
    @(posedge sys_clk);
    gpio_ctrl <= v;
  endtask

  // hold the button low for n clocks, then let it go
  task automatic press(input int n);
    @(posedge sys_clk);
    pushbutton_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    pushbutton_n <= 1'b1;
  endtask

  // die temperature sensor level
  task automatic heat(input logic v);
    @(posedge sys_clk);
    over_temp <= v;
  endtask
endmodule // dstc_host_pins

// *** testbench/tb.sv ***
module tb
  import dstc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LP = 20;

  typedef struct {logic [7:0] v; logic [7:0] m;} dstc_exp_t;

  logic       sys_clk;
  logic       rst = 1'b1;
  logic       sel = 1'b0;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic       rd_d = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [4:0] reg_enable;
  logic       reset_out_n, deep_sleep, irq, gpio_ctrl, pushbutton_n, over_temp;
  int         num_errors = 0;
  int         checks = 0;
  dstc_exp_t  exp_q[$];
  dstc_exp_t  cur;

  dstc_ctrl #(.LONG_PRESS_CYCLES(LP)) dut
  (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .factory_config_image(sel), .gpio_ctrl(gpio_ctrl),
    .pushbutton_n(pushbutton_n), .over_temp(over_temp), .reg_enable(reg_enable),
    .reset_out_n(reset_out_n), .deep_sleep(deep_sleep), .irq(irq)
  );

  dstc_host_pins pins
  (
    .sys_clk(sys_clk), .gpio_ctrl(gpio_ctrl), .pushbutton_n(pushbutton_n),
    .over_temp(over_temp)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] e, input string w);
    checks++;
    if (got !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, w, got, e);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // note the expected value, the monitor compares it a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back('{e, m});
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask

  task automatic do_reset(input logic s);
    @(posedge sys_clk);
    rst <= 1'b1;
    sel <= s;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    wt(2);
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (rd_d && exp_q.size() > 0)
    begin
      cur = exp_q.pop_front();
      chk(rdata & cur.m, cur.v, "rdata");
    end
    else if (!rst)
      chk(rdata, 8'h00, "idle rdata");
    rd_d <= rd_en;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    wrap_up();
  end

  initial
  begin
    logic [7:0] r;
    logic       e;
    void'($urandom(32'hd5c305d3));
    do_reset(1'b0);
    chk({3'h0, reg_enable}, 8'h1f, "reset enables");
    chk({5'h0, reset_out_n, deep_sleep, irq}, 8'h04, "reset pins");
    rd(REG_DS_ONOFF, DS_ONOFF_RST);
    rd(REG_DELAY_BASE + 8'h04, DELAY_RST);
    rd(REG_IRQ_EN, {4'h0, IRQ_EN_RST});
    rd(8'hff, 8'h00);
    r = 8'($urandom()) & 8'h1f;
    wr(REG_LS_ONOFF, r);
    rd(REG_LS_ONOFF, r, 8'h1f);
    rd(REG_DS_ONOFF, 8'h00, 8'h1f);
    endt("reset");
    for (int s = 0; s < 2; s++)
    begin
      do_reset(s[0]);
      for (int i = 0; i < 8; i++)
      begin
        pins.set_gpio(i[2]);
        wr(REG_CTRL, {5'h0, i[1], ~s[0], i[0]});
        wt(6);
        e = i[1] ? (s[0] ? (i[0] | i[2]) : (i[0] & i[2])) : i[0];
        chk({7'h0, deep_sleep}, {7'h0, e}, "deep sleep");
        rd(REG_CTRL, {5'h0, i[1], s[0], i[0]}, 8'h07);
        rd(REG_STATUS, {7'h0, e}, 8'h01);
      end
      endt("combine");
    end
    wr(REG_CTRL, 8'h00);
    pins.set_gpio(1'b0);
    wt(2000);
    wr(REG_DS_ONOFF, 8'h01);
    wr(REG_DELAY_BASE + 8'h01, 8'h04);
    wr(REG_CTRL, 8'h01);
    wt(800);
    chk({3'h0, reg_enable}, 8'h03, "entry early");
    wt(1000);
    chk({3'h0, reg_enable}, 8'h01, "entry done");
    wr(REG_CTRL, 8'h00);
    wt(800);
    chk({3'h0, reg_enable}, 8'h1d, "exit early");
    wt(1000);
    chk({3'h0, reg_enable}, 8'h1f, "exit done");
    endt("sequencing");
    wr(REG_IRQ_EN, 8'h08);
    wr(REG_CTRL, 8'h01);
    wt(6);
    pins.press(LP - 8);
    wt(6);
    chk({7'h0, deep_sleep}, 8'h01, "short press");
    pins.press(LP + 8);
    wt(6);
    chk({7'h0, deep_sleep}, 8'h00, "long press");
    rd(REG_CTRL, 8'h00, 8'h01);
    rd(REG_IRQ_STAT, 8'h08, 8'h08);
    wt(2);
    chk({7'h0, irq}, 8'h01, "irq raised");
    wr(REG_IRQ_EN, 8'h00);
    wt(2);
    chk({7'h0, irq}, 8'h00, "irq masked");
    wr(REG_IRQ_EN, 8'h08);
    wr(REG_IRQ_CLR, 8'h08);
    wt(2);
    chk({7'h0, irq}, 8'h00, "irq cleared");
    rd(REG_IRQ_STAT, 8'h00, 8'h08);
    endt("pushbutton");
    wr(REG_IRQ_CLR, 8'h0f);
    wr(REG_MASK, 8'h20);
    wr(REG_IRQ_EN, 8'h01);
    for (int m = 0; m < 2; m++)
    begin
      pins.heat(1'b1);
      wt(6);
      chk({2'h0, reset_out_n, reg_enable}, 8'h00, "thermal off");
      chk({7'h0, irq}, 8'(m), "thermal irq");
      rd(REG_STATUS, 8'h02, 8'h03);
      pins.heat(1'b0);
      wt(6);
      chk({7'h0, reset_out_n}, 8'h01, "thermal reset release");
      rd(REG_STATUS, 8'h00, 8'h03);
      // outputs come back through their own delays, slowest is 5 ticks
      wt(1300);
      chk({2'h0, reset_out_n, reg_enable}, 8'h3f, "thermal exit");
      wr(REG_MASK, 8'h00);
    end
    endt("thermal");
    wt(4);
    wrap_up();
  end
endmodule // tb
